// ===== rtl/mslope_sequencer.sv
/*
  multislope conversion sequencer: frames, analog switch selects, result.
  assumes an oscillator pin and a comparator level, both asynchronous,
  plus host select, strobe and mode pins.
*/
`timescale 1ns/1ps
module mslope_sequencer
  import mslope_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              osc_in,
  input  wire logic              comp_in,
  input  wire logic              mode_cont,
  input  wire logic              chip_sel,
  input  wire logic              chip_en_n,
  input  wire logic              start_n,
  output logic                   busy,
  output mslope_pkg::sw_t        sw,
  output logic [RES_W-1:0]       result,
  output logic                   overrange,
  output logic                   polarity,
  output logic                   data_valid
);
  import mslope_pkg::*;

  typedef struct packed {
    logic [PIN_N-1:0]  s1;
    logic [PIN_N-1:0]  s2;
    logic [PIN_N-1:0]  s3;
    logic [PIN_N-1:0]  lvl;
    logic              strobe;
    logic              pending;
    phase_t            phase;
    logic [CNT_W-1:0]  cnt;
    logic [SLOT_W-1:0] slot;
    logic              sense;
    logic              stop;
    logic              done;
    logic              pol;
    logic              ovr;
    logic [CNT_W-1:0]  fast_cnt;
    logic [SLOW_W:0]   slow_cnt;
    logic [OVR_W-1:0]  ovr_cnt;
    logic              busy;
    sw_t               sw;
    logic [RES_W-1:0]  result;
    logic              ovr_out;
    logic              pol_out;
    logic              valid;
  } seq_t;

  seq_t             st_q;
  seq_t             st_d;
  tick_if           tk ();
  logic [PIN_N-1:0] lvl_nx;
  logic [PIN_N-1:0] pins;
  logic             req;
  logic             last;
  logic             count_en;

  osc_prescaler u_pre (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .osc_in  (osc_in),
    .tk      (tk)
  );

  // ==========================================================
  // pin filtering: a change counts once stages two and three agree
  assign pins = {start_n, chip_en_n, chip_sel, mode_cont, comp_in};

  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    assign lvl_nx[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.lvl[i];
  end

  assign req = st_q.lvl[PIN_CS] & ~st_q.lvl[PIN_CEN] & ~st_q.lvl[PIN_WRN];

  always_comb begin
    last = 1'b0;
    unique case (st_q.phase)
      PH_IDLE:   last = 1'b0;
      PH_ZERO:   last = st_q.cnt == CNT_W'(ZERO_CYC - 1);
      PH_SIG:    last = st_q.cnt == CNT_W'(SIG_CYC - 1);
      PH_FAST:   last = st_q.cnt == CNT_W'(FAST_CYC - 1);
      PH_SLOW:   last = st_q.cnt == CNT_W'(SLOW_CYC - 1);
      PH_OVR:    last = st_q.cnt == CNT_W'(OVR_SLOT_CYC - 1);
      PH_SETTLE: last = st_q.cnt == CNT_W'(SETTLE_CYC - 1);
    endcase
  end

  // crossing ends counting for the rest of the slot; slot itself runs out
  assign count_en = !st_q.done && !st_q.stop && (st_q.lvl[PIN_COMP] == st_q.sense);

  // ==========================================================
  // sequencing
  always_comb begin
    st_d     = st_q;
    st_d.s1  = pins;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.lvl = lvl_nx;
    st_d.strobe = req;
    // a strobe arriving outside PH_IDLE is dropped; one frame per strobe
    if (req && !st_q.strobe && !st_q.lvl[PIN_MODE] && st_q.phase == PH_IDLE) begin
      st_d.pending = 1'b1;
    end
    if (tk.tick) begin
      st_d.cnt = st_q.cnt + 1'b1;
      if (st_q.phase != PH_IDLE && !last) begin
        unique case (st_q.phase)
          PH_FAST: if (count_en) st_d.fast_cnt = st_q.fast_cnt + 1'b1;
          PH_SLOW: if (count_en) st_d.slow_cnt = st_q.slow_cnt + 1'b1;
          PH_OVR:  if (count_en) st_d.ovr_cnt = st_q.ovr_cnt + 1'b1;
          default: ;
        endcase
        if ((st_q.phase == PH_FAST || st_q.phase == PH_SLOW || st_q.phase == PH_OVR)
            && !count_en && !st_q.done) begin
          st_d.stop = 1'b1;
          if (st_q.phase != PH_FAST) begin
            st_d.done = 1'b1;
          end
        end
      end
      if (last || st_q.phase == PH_IDLE) begin
        st_d.cnt   = '0;
        st_d.stop  = 1'b0;
        st_d.sense = st_q.lvl[PIN_COMP];
      end
      unique case (st_q.phase)
        PH_IDLE: begin
          if (st_q.pending || st_q.lvl[PIN_MODE]) begin
            st_d.phase   = PH_ZERO;
            st_d.pending = 1'b0;
          end
        end
        PH_ZERO: if (last) st_d.phase = PH_SIG;
        PH_SIG: begin
          if (last) begin
            st_d.phase    = PH_FAST;
            st_d.pol      = st_q.lvl[PIN_COMP];
            st_d.fast_cnt = '0;
            st_d.slow_cnt = '0;
            st_d.ovr_cnt  = '0;
            st_d.done     = 1'b0;
            st_d.ovr      = 1'b0;
          end
        end
        PH_FAST: if (last) st_d.phase = PH_SLOW;
        PH_SLOW: begin
          if (last) begin
            st_d.phase = PH_OVR;
            st_d.slot  = '0;
            // still short of zero after the slow part: beyond full scale
            if (!st_q.done) begin
              st_d.ovr = 1'b1;
            end
          end
        end
        PH_OVR: begin
          if (last) begin
            st_d.slot = st_q.slot + 1'b1;
            if (st_q.slot == SLOT_W'(OVR_SLOTS - 1)) begin
              st_d.phase = PH_SETTLE;
            end
          end
        end
        PH_SETTLE: begin
          if (last) begin
            st_d.phase   = st_q.lvl[PIN_MODE] ? PH_ZERO : PH_IDLE;
            st_d.ovr_out = st_q.ovr;
            st_d.pol_out = st_q.pol;
            st_d.valid   = 1'b1;
            if (st_q.ovr) begin
              st_d.result = RES_W'(st_q.ovr_cnt);
            end else begin
              st_d.result = {st_q.fast_cnt[FAST_W-1:0], st_q.slow_cnt[SLOW_W-1:0]};
            end
          end
        end
      endcase
    end
    st_d.busy = st_d.phase inside {PH_FAST, PH_SLOW, PH_OVR, PH_SETTLE};
    // only a start from idle clears valid: back-to-back frames keep valid high
    if (st_d.phase == PH_ZERO && st_q.phase == PH_IDLE) begin
      st_d.valid = 1'b0;
    end
    st_d.sw = '0;
    unique case (st_d.phase)
      PH_IDLE, PH_ZERO: begin
        st_d.sw.null_loop    = 1'b1;
        st_d.sw.in_to_common = 1'b1;
      end
      PH_SIG:  st_d.sw.in_connect = 1'b1;
      PH_FAST: begin
        st_d.sw.neg_to_common = 1'b1;
        st_d.sw.pos_main_cap  = 1'b1;
      end
      PH_SLOW, PH_OVR: begin
        st_d.sw.neg_to_common = 1'b1;
        st_d.sw.pos_fine_cap  = 1'b1;
      end
      PH_SETTLE: st_d.sw.in_to_common = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q       <= '0;
      st_q.s1    <= PIN_RST;
      st_q.s2    <= PIN_RST;
      st_q.s3    <= PIN_RST;
      st_q.lvl   <= PIN_RST;
      st_q.phase <= PH_IDLE;
      st_q.sw    <= '{null_loop: 1'b1, in_to_common: 1'b1, default: 1'b0};
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign busy       = st_q.busy;
  assign sw         = st_q.sw;
  assign result     = st_q.result;
  assign overrange  = st_q.ovr_out;
  assign polarity   = st_q.pol_out;
  assign data_valid = st_q.valid;

endmodule

// ===== rtl/mslope_pkg.sv
/*
  shared constants, types and phase enumeration of the multislope sequencer.
  assumes a single ref_clk domain; analog switches are driven by plain levels.
*/
package mslope_pkg;

  // ==========================================================
  // divider and frame slots
  localparam int unsigned OSC_DIV      = 4;
  localparam int unsigned ZERO_CYC     = 246;
  localparam int unsigned SIG_CYC      = 256;
  localparam int unsigned FAST_CYC     = 512;
  localparam int unsigned SLOW_CYC     = 64;
  localparam int unsigned OVR_SLOT_CYC = 64;
  localparam int unsigned OVR_SLOTS    = 3;
  localparam int unsigned SETTLE_CYC   = 10;
  localparam int unsigned FRAME_CYC    = 1280;

  // ==========================================================
  // widths
  localparam int unsigned CNT_W    = 10;
  localparam int unsigned FAST_W   = 9;
  localparam int unsigned SLOW_W   = 6;
  localparam int unsigned OVR_W    = 8;
  localparam int unsigned RES_W    = 15;
  localparam int unsigned DIV_W    = 2;
  localparam int unsigned SLOT_W   = 2;
  localparam int unsigned PIN_N    = 5;

  // ==========================================================
  // synchronised pin positions
  localparam int unsigned PIN_COMP = 0;
  localparam int unsigned PIN_MODE = 1;
  localparam int unsigned PIN_CS   = 2;
  localparam int unsigned PIN_CEN  = 3;
  localparam int unsigned PIN_WRN  = 4;

  localparam logic [PIN_N-1:0] PIN_RST = 5'h18;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ZERO,
    PH_SIG,
    PH_FAST,
    PH_SLOW,
    PH_OVR,
    PH_SETTLE
  } phase_t;

  typedef struct packed {
    logic null_loop;
    logic in_to_common;
    logic in_connect;
    logic neg_to_common;
    logic pos_main_cap;
    logic pos_fine_cap;
  } sw_t;

endpackage

// ===== rtl/tick_if.sv
/*
  carries the divided-oscillator tick from the prescaler to the sequencer.
  assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// ===== rtl/osc_prescaler.sv
/*
  oscillator prescaler: synchronises the oscillator pin and emits one
  ref_clk pulse per OSC_DIV accepted rising edges.
  assumes the oscillator is well below ref_clk/3.
*/
`timescale 1ns/1ps
module osc_prescaler
  import mslope_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic osc_in,
  tick_if.src       tk
);

  typedef struct packed {
    logic             s1;
    logic             s2;
    logic             s3;
    logic             lvl;
    logic [DIV_W-1:0] div;
    logic             tick;
  } pre_t;

  pre_t st_q;
  pre_t st_d;

  // ==========================================================
  // divide by four on filtered rising edges
  always_comb begin
    st_d      = st_q;
    st_d.s1   = osc_in;
    st_d.s2   = st_q.s1;
    st_d.s3   = st_q.s2;
    st_d.tick = 1'b0;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
      if (st_q.s3 && !st_q.lvl) begin
        st_d.div = st_q.div + 1'b1;
        if (st_q.div == DIV_W'(OSC_DIV - 1)) begin
          st_d.tick = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // tick held low while frozen so nothing counts twice
  assign tk.tick = st_q.tick & clk_en;

endmodule

// ===== tb/mslope_sequencer_asserts.sv
/* port assertions for the multislope sequencer.
   assumes one ref_clk domain and osc_in changed away from the rising edge. */
`timescale 1ns/1ps
module mslope_sequencer_asserts (
  input wire logic                     ref_clk,
  input wire logic                     sys_rst,
  input wire logic                     clk_en,
  input wire logic                     osc_in,
  input wire logic                     comp_in,
  input wire logic                     mode_cont,
  input wire logic                     chip_sel,
  input wire logic                     chip_en_n,
  input wire logic                     start_n,
  input wire logic                     busy,
  input wire mslope_pkg::sw_t          sw,
  input wire logic [mslope_pkg::RES_W-1:0] result,
  input wire logic                     overrange,
  input wire logic                     polarity,
  input wire logic                     data_valid
);
  import mslope_pkg::*;
  // ==========================================================
  // raw osc edge counts; slack covers the pin filter delay
  logic        osc_q;
  logic        busy_q;
  logic        mode_q;
  logic        zero_arm_q;
  logic [11:0] busy_n_q;
  logic [11:0] sig_n_q;
  logic [11:0] zero_n_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_q      <= 1'b0;
      busy_q     <= 1'b0;
      mode_q     <= 1'b0;
      zero_arm_q <= 1'b0;
      busy_n_q   <= 12'h0;
      sig_n_q    <= 12'h0;
      zero_n_q   <= 12'h0;
    end else begin
      osc_q    <= osc_in;
      busy_q   <= busy;
      mode_q   <= mode_cont;
      busy_n_q <= busy ? busy_n_q + 12'(osc_in & ~osc_q) : 12'h0;
      sig_n_q  <= sw.in_connect ? sig_n_q + 12'(osc_in & ~osc_q) : 12'h0;
      // only a zero phase entered straight from a continuous frame end is timed
      zero_n_q <= busy ? 12'h0 : zero_n_q + 12'(osc_in & ~osc_q);
      if (busy_q && !busy && mode_q) begin
        zero_arm_q <= 1'b1;
      end else if (sw.in_connect) begin
        zero_arm_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  busy_len_a: assert property (
    $fell(busy) |-> busy_n_q inside {[12'hc24:12'hc2c]})
    else $error("deintegrate length off");
  sig_len_a: assert property (
    $fell(sw.in_connect) |-> sig_n_q inside {[12'h3fc:12'h404]})
    else $error("signal integrate length off");
  zero_len_a: assert property (
    $rose(sw.in_connect) && zero_arm_q |-> zero_n_q inside {[12'h3d4:12'h3dc]})
    else $error("zero phase length off");
  frame_end_a: assert property (
    $fell(busy) |-> data_valid && sw.null_loop)
    else $error("frame end without valid data");
  busy_start_a: assert property (
    $rose(busy) |-> $past(sw.in_connect) && sw.pos_main_cap)
    else $error("busy rose outside signal to fast step");
  sig_after_zero_a: assert property (
    $rose(sw.in_connect) |-> $past(sw.null_loop))
    else $error("signal phase not after zero phase");
  zero_sw_a: assert property (
    sw.null_loop |-> sw.in_to_common && !sw.in_connect && !busy)
    else $error("zero phase switches wrong");
  sig_sw_a: assert property (
    sw.in_connect |-> !sw.null_loop && !sw.in_to_common && !busy)
    else $error("signal phase switches wrong");
  fast_sw_a: assert property (
    sw.pos_main_cap |-> sw.neg_to_common && !sw.pos_fine_cap && busy)
    else $error("fast phase switches wrong");
  fine_sw_a: assert property (
    sw.pos_fine_cap |-> sw.neg_to_common && busy)
    else $error("slow phase switches wrong");
  result_hold_a: assert property (
    !$fell(busy) |-> $stable(result) && $stable(overrange) && $stable(polarity))
    else $error("result moved outside frame end");
endmodule

// ===== tb/afe_model.sv
/* comparator side of the analog front end.
   assumes the bench osc period of 6 ref_clk cycles, so one tick is 24. */
`timescale 1ns/1ps
module afe_model (
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire mslope_pkg::sw_t sw,
  input  wire logic            pos,
  input  wire logic [15:0]     n_fast,
  input  wire logic [15:0]     n_slow,
  output logic                 comp_in
);
  import mslope_pkg::*;
  // ==========================================================
  // crossing timers, half a tick past the commanded count
  localparam int TK = 24;
  logic [19:0] fast_q;
  logic [19:0] fine_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fast_q  <= 20'h0;
      fine_q  <= 20'h0;
      comp_in <= 1'b0;
    end else if (sw.null_loop) begin
      fast_q  <= 20'h0;
      fine_q  <= 20'h0;
      comp_in <= pos;
    end else begin
      if (sw.pos_main_cap) fast_q <= fast_q + 20'h1;
      // keeps running across slot gaps so overrange slots continue the ramp
      if (sw.pos_fine_cap || fine_q != 20'h0) fine_q <= fine_q + 20'h1;
      if (sw.pos_main_cap && int'(fast_q) == int'(n_fast) * TK + TK / 2) comp_in <= ~comp_in;
      if (int'(fine_q) == int'(n_slow) * TK + TK / 2) comp_in <= ~comp_in;
    end
  end
endmodule

// ===== tb/tb.sv
/* self-checking bench for the multislope sequencer.
   assumes afe_model drives the comparator and the bench drives the host pins. */
`timescale 1ns/1ps
module tb;
  import mslope_pkg::*;
  localparam int TK = 24;
  logic             ref_clk, sys_rst, clk_en, osc_in, comp_in, mode_cont, pos;
  logic             chip_sel, chip_en_n, start_n, busy, overrange, polarity, data_valid;
  sw_t              sw;
  logic [RES_W-1:0] result;
  logic [15:0]      n_fast, n_slow;
  int               n_mismatch = 0;
  int               compares = 0;
  int               cyc = 0;
  int               t0;
  mslope_sequencer dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .osc_in(osc_in),
    .comp_in(comp_in), .mode_cont(mode_cont), .chip_sel(chip_sel), .chip_en_n(chip_en_n),
    .start_n(start_n), .busy(busy), .sw(sw), .result(result), .overrange(overrange),
    .polarity(polarity), .data_valid(data_valid));
  afe_model afe (.ref_clk(ref_clk), .sys_rst(sys_rst), .sw(sw), .pos(pos), .n_fast(n_fast),
    .n_slow(n_slow), .comp_in(comp_in));
  // ==========================================================
  // clocks and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    osc_in = 1'b0;
    forever begin
      repeat (3) @(negedge ref_clk);
      osc_in = ~osc_in;
    end
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ==========================================================
  // tasks
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a crossing may land either side of a tick boundary
  task near(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e && g !== e + 16'h1) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 40000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("busy wait", {15'h0, lvl}, {15'h0, busy});
  endtask
  task strobe(input logic sel);
    chip_sel = sel;
    start_n = 1'b0;
    repeat (8) @(negedge ref_clk);
    start_n = 1'b1;
  endtask
  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    mode_cont = 1'b0;
    chip_sel = 1'b0;
    chip_en_n = 1'b0;
    start_n = 1'b1;
    pos = 1'b1;
    n_fast = 16'h012c;
    n_slow = 16'h0028;
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("sw reset", 16'h0030, {10'h0, sw});
    chk("busy result reset", 16'h0, {busy, result});
    strobe(1'b0);
    // a strobe while frozen must leave no trace once the enable returns
    clk_en = 1'b0;
    repeat (2) @(negedge ref_clk);
    strobe(1'b1);
    repeat (2) @(negedge ref_clk);
    clk_en = 1'b1;
    // long enough that a wrongly started frame would be integrating by now
    repeat (6500) @(negedge ref_clk);
    chk("no frame started", 16'h0030, {9'h0, busy, sw});
    strobe(1'b1);
    wait_busy(1'b1);
    t0 = cyc;
    wait_busy(1'b0);
    chk("deint len", 16'((FAST_CYC + SLOW_CYC + OVR_SLOTS * OVR_SLOT_CYC + SETTLE_CYC) * TK),
      16'(cyc - t0));
    near("fast count", 16'h012c, {7'h0, result[14:6]});
    near("slow count", 16'h0028, {10'h0, result[5:0]});
    chk("flags", 16'h0003, {13'h0, overrange, polarity, data_valid});
    pos = 1'b0;
    n_fast = 16'h0258;
    n_slow = 16'h0072;
    mode_cont = 1'b1;
    wait_busy(1'b1);
    t0 = cyc;
    wait_busy(1'b0);
    chk("ovr high bits", 16'h0, {9'h0, result[14:8]});
    near("ovr count", 16'h0032, {8'h0, result[7:0]});
    chk("ovr flags", 16'h0005, {13'h0, overrange, polarity, data_valid});
    wait_busy(1'b1);
    chk("frame len", 16'(FRAME_CYC * TK), 16'(cyc - t0));
    stop_test();
  end
endmodule
bind mslope_sequencer mslope_sequencer_asserts chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .osc_in(osc_in), .comp_in(comp_in), .mode_cont(mode_cont),
  .chip_sel(chip_sel), .chip_en_n(chip_en_n), .start_n(start_n), .busy(busy), .sw(sw),
  .result(result), .overrange(overrange), .polarity(polarity), .data_valid(data_valid));
